// file: rtl/rtdvp_top.v
// Per-channel value processing and cyclic hand-over, four channels.
// Assumes an external converter answering start pulses on this clock and
// configuration ports held stable while cfg_pend_o is high.
`timescale 1ns/1ps
`include "rtdvp_consts.vh"
module rtdvp_top #(
    parameter CONV_CYC   = `RTDVP_CONV_CYC,
    parameter CONV3W_CYC = `RTDVP_CONV3W_CYC,
    parameter HAND_CYC   = `RTDVP_HAND_CYC,
    parameter APPLY_CYC  = `RTDVP_APPLY_CYC
) (
    input  wire        clk_i,
    input  wire        rstn_i,
    output wire        adc_start_o,
    output wire [1:0]  adc_chan_o,
    input  wire [15:0] adc_data_i,
    input  wire        adc_fault_i,
    input  wire        cfg_load_i,
    output wire        cfg_pend_o,
    input  wire [3:0]  cfg_active_i,
    input  wire [3:0]  cfg_3wire_i,
    input  wire        cfg_sim_i,
    input  wire [1:0]  cfg_err_mode_i,
    input  wire        cfg_with_status_i,
    input  wire [15:0] cfg_range_start_i,
    input  wire [15:0] cfg_range_end_i,
    input  wire [15:0] cfg_min_tx_i,
    input  wire [15:0] cfg_max_tx_i,
    input  wire [7:0]  cfg_filter_pct_i,
    input  wire [8:0]  cfg_subst_pct_i,
    input  wire        cfg_subst_st_i,
    input  wire        cfg_subst_lb_i,
    input  wire        cfg_subst_inv_i,
    input  wire [8:0]  cfg_sim_pct_i,
    input  wire        cfg_sim_st_i,
    input  wire        cfg_sim_lb_i,
    input  wire        cfg_sim_inv_i,
    input  wire        cfg_line_fault_check_i,
    input  wire [7:0]  cfg_fault_clear_cycles_i,
    output wire        bu_valid_o,
    input  wire        bu_ready_i,
    output wire [1:0]  bu_chan_o,
    output wire [15:0] bu_data_o,
    output wire [3:0]  chan_fault_o
);
    localparam S_PICK = 2'h0;
    localparam S_WAIT = 2'h1;
    localparam S_PROC = 2'h2;
    reg         rs1_q;
    reg         rs2_q;
    wire        rst_n;
    reg  [1:0]  st_q;
    reg  [1:0]  cv_ch_q;
    reg  [31:0] tmr_q;
    reg         start_q;
    reg  [15:0] samp_q;
    reg         pflt_q;
    reg         pend_q;
    reg  [31:0] apl_q;
    reg  [3:0]  act_q;
    reg  [3:0]  w3_q;
    reg         sim_q;
    reg  [1:0]  em_q;
    reg         wst_q;
    reg  [15:0] rs_q;
    reg  [15:0] re_q;
    reg  [15:0] mn_q;
    reg  [15:0] mx_q;
    reg  [7:0]  fp_q;
    reg  [8:0]  sbp_q;
    reg  [2:0]  sbf_q;
    reg  [8:0]  smp_q;
    reg  [2:0]  smf_q;
    reg         lfc_q;
    reg  [7:0]  fcc_q;
    reg  [15:0] filt_q [0:3];
    reg  [15:0] last_q [0:3];
    reg  [15:0] word_q [0:3];
    reg  [7:0]  good_q [0:3];
    reg  [3:0]  bad_q;
    reg  [3:0]  seen_q;
    reg  [31:0] hnd_q;
    reg         tick_q;
    reg  [1:0]  hch_q;
    wire        f_ready;
    wire        apply;
    integer     i;
    // Percent of range to raw word; 0% is range start, 100% range end
    function [15:0] pct2raw;
        input [8:0]  pct;
        input [15:0] rs;
        input [15:0] re;
        input [15:0] lo;
        input [15:0] hi;
        reg signed [17:0] diff;
        reg signed [27:0] val;
        begin
            diff = $signed({2'b00, re}) - $signed({2'b00, rs});
            val  = $signed(pct) * diff / 28'sd100;
            val  = val + $signed({12'h000, rs});
            pct2raw = clampv(val, lo, hi);
        end
    endfunction
    function [15:0] clampv;
        input signed [27:0] v;
        input [15:0]        lo;
        input [15:0]        hi;
        begin
            if (v < $signed({12'h000, lo})) begin
                clampv = lo;
            end else if (v > $signed({12'h000, hi})) begin
                clampv = hi;
            end else begin
                clampv = v[15:0];
            end
        end
    endfunction
    // Reset is released through two flops; assertion stays asynchronous
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    assign rst_n = rs2_q;
    // Download waits for the next round start, bounded by the apply timer
    assign apply = pend_q & (((st_q == S_PICK) & (cv_ch_q == 2'h0))
                   | (apl_q == 32'h0000_0000));
    assign cfg_pend_o = pend_q;
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            apl_q  <= 32'h0000_0000;
            act_q  <= 4'h0;
            w3_q   <= 4'h0;
            sim_q  <= 1'b0;
            em_q   <= `RTDVP_ERR_CURRENT;
            wst_q  <= 1'b0;
            rs_q   <= `RTDVP_STD_START;
            re_q   <= `RTDVP_STD_END;
            mn_q   <= 16'h0000;
            mx_q   <= 16'hFFFF;
            fp_q   <= 8'h00;
            sbp_q  <= 9'h000;
            sbf_q  <= 3'h0;
            smp_q  <= 9'h000;
            smf_q  <= 3'h0;
            lfc_q  <= 1'b0;
            fcc_q  <= 8'h00;
        end else if (cfg_load_i) begin
            pend_q <= 1'b1;
            apl_q  <= APPLY_CYC - 1;
        end else if (apply) begin
            pend_q <= 1'b0;
            act_q  <= cfg_active_i;
            w3_q   <= cfg_3wire_i;
            sim_q  <= cfg_sim_i;
            em_q   <= cfg_err_mode_i;
            wst_q  <= cfg_with_status_i;
            rs_q   <= cfg_range_start_i;
            re_q   <= cfg_range_end_i;
            mn_q   <= cfg_min_tx_i;
            mx_q   <= cfg_max_tx_i;
            fp_q   <= cfg_filter_pct_i;
            sbp_q  <= cfg_subst_pct_i;
            sbf_q  <= {cfg_subst_st_i, cfg_subst_lb_i, cfg_subst_inv_i};
            smp_q  <= cfg_sim_pct_i;
            smf_q  <= {cfg_sim_st_i, cfg_sim_lb_i, cfg_sim_inv_i};
            lfc_q  <= cfg_line_fault_check_i;
            fcc_q  <= cfg_fault_clear_cycles_i;
        end else if (pend_q) begin
            apl_q <= apl_q - 32'h0000_0001;
        end
    end
    // Conversion sequencer: one channel at a time, skipping idle ones
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= S_PICK;
            cv_ch_q <= 2'h0;
            tmr_q   <= 32'h0000_0000;
            start_q <= 1'b0;
            samp_q  <= 16'h0000;
            pflt_q  <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (st_q)
                S_PICK: begin
                    if (act_q[cv_ch_q] & ~apply) begin
                        start_q <= 1'b1;
                        st_q    <= S_WAIT;
                        tmr_q   <= w3_q[cv_ch_q] ? CONV3W_CYC - 1
                                                 : CONV_CYC - 1;
                    end else if (~apply) begin
                        cv_ch_q <= cv_ch_q + 2'h1;
                    end
                end
                S_WAIT: begin
                    if (tmr_q == 32'h0000_0000) begin
                        samp_q <= adc_data_i;
                        pflt_q <= adc_fault_i & lfc_q;
                        st_q   <= S_PROC;
                    end else begin
                        tmr_q <= tmr_q - 32'h0000_0001;
                    end
                end
                S_PROC: begin
                    cv_ch_q <= cv_ch_q + 2'h1;
                    st_q    <= S_PICK;
                end
                default: begin
                    st_q <= S_PICK;
                end
            endcase
        end
    end
    assign adc_start_o = start_q;
    assign adc_chan_o  = cv_ch_q;
    // Value path for the channel just converted
    reg  [15:0] nf;
    reg  [31:0] step;
    reg  [16:0] gap;
    reg         badn;
    reg         flt;
    reg         inv;
    reg  [15:0] val;
    reg  [15:0] meas;
    reg  [3:0]  sts;
    reg  [7:0]  gn;
    always @* begin
        gap  = 17'h0_0000;
        step = {24'h00_0000, fp_q} * {16'h0000, re_q - rs_q}
               * (w3_q[cv_ch_q] ? `RTDVP_T_CONV3W_MS : `RTDVP_T_CONV_MS)
               / `RTDVP_RAMP_DIV;
        if (step == 32'h0000_0000) begin
            step = 32'h0000_0001;
        end
        nf = samp_q;
        if (fp_q != 8'h00 && seen_q[cv_ch_q]) begin
            if (samp_q > filt_q[cv_ch_q]) begin
                gap = {1'b0, samp_q - filt_q[cv_ch_q]};
                if ({15'h0000, gap} > step) begin
                    nf = filt_q[cv_ch_q] + step[15:0];
                end
            end else begin
                gap = {1'b0, filt_q[cv_ch_q] - samp_q};
                if ({15'h0000, gap} > step) begin
                    nf = filt_q[cv_ch_q] - step[15:0];
                end
            end
        end
        gn = good_q[cv_ch_q] + 8'h01;
        badn = pflt_q | (bad_q[cv_ch_q] & (gn < fcc_q));
        meas = clampv({12'h000, nf}, mn_q, mx_q);
        inv  = sim_q & smf_q[2] & smf_q[0];
        flt  = badn | inv;
        val  = sim_q ? pct2raw(smp_q, rs_q, re_q, mn_q, mx_q)
                     : meas;
        sts  = 4'h0;
        sts[`RTDVP_ST_LINE_BIT] = badn;
        if (sim_q) begin
            sts[`RTDVP_ST_LINE_BIT] = smf_q[2] & smf_q[1] & badn;
            sts[`RTDVP_ST_INV_BIT]  = inv;
        end
        if (flt && em_q == `RTDVP_ERR_SUBST) begin
            val = pct2raw(sbp_q, rs_q, re_q, mn_q, mx_q);
            sts[`RTDVP_ST_LINE_BIT] = sbf_q[2] & sbf_q[1] & badn;
            sts[`RTDVP_ST_INV_BIT]  = sbf_q[2] & sbf_q[0];
        end else if (flt && em_q == `RTDVP_ERR_LAST) begin
            val = last_q[cv_ch_q];
        end
    end
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bad_q  <= 4'h0;
            seen_q <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                filt_q[i] <= 16'h0000;
                last_q[i] <= 16'h0000;
                word_q[i] <= 16'h0000;
                good_q[i] <= 8'h00;
            end
        end else if (st_q == S_PROC) begin
            filt_q[cv_ch_q] <= nf;
            seen_q[cv_ch_q] <= 1'b1;
            bad_q[cv_ch_q]  <= badn;
            good_q[cv_ch_q] <= (pflt_q | ~badn) ? 8'h00 : gn;
            if (!flt) begin
                last_q[cv_ch_q] <= val;
            end
            // Status rides in the low nibble only for standard scaling
            if (wst_q && rs_q == `RTDVP_STD_START
                      && re_q == `RTDVP_STD_END) begin
                word_q[cv_ch_q] <= {val[15:4], sts};
            end else begin
                word_q[cv_ch_q] <= val;
            end
        end
    end
    assign chan_fault_o = bad_q;
    // Hand-over pacing; a tick waits while the FIFO is full
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hnd_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
            hch_q  <= 2'h0;
        end else begin
            if (hnd_q == HAND_CYC - 1) begin
                hnd_q  <= 32'h0000_0000;
                tick_q <= 1'b1;
            end else begin
                hnd_q <= hnd_q + 32'h0000_0001;
            end
            if (tick_q & f_ready) begin
                hch_q <= hch_q + 2'h1;
                if (hnd_q != HAND_CYC - 1) begin
                    tick_q <= 1'b0;
                end
            end
        end
    end
    rtdvp_fifo #(
        .WIDTH (18),
        .DEPTH (`RTDVP_FIFO_DEPTH),
        .AW    (`RTDVP_FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rstn_i      (rst_n),
        .in_valid_i  (tick_q),
        .in_ready_o  (f_ready),
        .in_data_i   ({hch_q, word_q[hch_q]}),
        .out_valid_o (bu_valid_o),
        .out_ready_i (bu_ready_i),
        .out_data_o  ({bu_chan_o, bu_data_o})
    );
endmodule

// file: rtl/rtdvp_consts.vh
// Constants for the four-channel resistive input value processing block.
// Assumes a 20 MHz system clock; included by bare name.
// Contract
// - Damping ramps each input at configured percent of span per second; code steps by its own conversion time once per round of all active channels.
// - Sent value is clamped between configured lower and upper limits.
// - On fault with substitute mode, send substitute percent (-25..125).
// - Substitute word carries chosen line-break and invalid flags if enabled; code sets the line-break flag only while a line fault is present.
// - Simulation mode sends simulation percent instead of measured value.
// - Simulation invalid flag makes channel faulty, error mode then applies; code needs the simulation status flag too, and chan_fault_o does not show it.
// - Conversion: 120 ms per active channel, 240 ms in three-wire mode.
// - A channel word goes to the bus unit every 6.5 ms.
// - Channels handed over one at a time, in turn.
// - New configuration takes effect within 15 s of download.
// - Process value is unsigned, 0 to 65535.
// - One 16-bit word per channel, low four bits hold status.
// - Status bits omitted unless scaling is 10000 to 50000.
// - Words are placed in ascending channel order, channel one first.
// - Input digitised to 16 bits, -200 to 850 degrees span.
// - Last-valid mode keeps sending the last fault-free value.
// - Channel good again only after configured fault-free cycles.
// - Word bit 1 is the line fault flag, 1 means error.
`ifndef RTDVP_CONSTS_VH
`define RTDVP_CONSTS_VH
`define RTDVP_CLK_MHZ      20
`define RTDVP_T_CONV_US    120000
`define RTDVP_T_CONV3W_US  240000
`define RTDVP_T_HAND_US    6500
`define RTDVP_T_APPLY_US   15000000
`define RTDVP_CONV_CYC     (`RTDVP_T_CONV_US * `RTDVP_CLK_MHZ)
`define RTDVP_CONV3W_CYC   (`RTDVP_T_CONV3W_US * `RTDVP_CLK_MHZ)
`define RTDVP_HAND_CYC     (`RTDVP_T_HAND_US * `RTDVP_CLK_MHZ)
`define RTDVP_APPLY_CYC    (`RTDVP_T_APPLY_US * `RTDVP_CLK_MHZ)
`define RTDVP_T_CONV_MS    120
`define RTDVP_T_CONV3W_MS  240
`define RTDVP_RAMP_DIV     100000
`define RTDVP_STD_START    16'h2710
`define RTDVP_STD_END      16'hC350
`define RTDVP_ST_LINE_BIT  1
`define RTDVP_ST_INV_BIT   3
`define RTDVP_ERR_CURRENT  2'h0
`define RTDVP_ERR_SUBST    2'h1
`define RTDVP_ERR_LAST     2'h2
`define RTDVP_FIFO_DEPTH   16
`define RTDVP_FIFO_AW      4
`endif

// file: rtl/rtdvp_fifo.v
// Small FIFO with valid/ready on both sides and registered read data.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/1ps
module rtdvp_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_i,
    input  wire             rstn_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_q;
    reg [AW-1:0]    rp_q;
    reg [AW:0]      cnt_q;
    reg [WIDTH-1:0] dout_q;
    reg             ov_q;
    wire            push;
    wire            pop;

    // Output register is not counted, so DEPTH words sit in memory
    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = (cnt_q != {(AW+1){1'b0}}) & (~ov_q | out_ready_i);
    assign out_valid_o = ov_q;
    assign out_data_o  = dout_q;

    always @(posedge clk_i) begin
        if (push) begin
            mem[wp_q] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_q   <= {AW{1'b0}};
            rp_q   <= {AW{1'b0}};
            cnt_q  <= {(AW+1){1'b0}};
            dout_q <= {WIDTH{1'b0}};
            ov_q   <= 1'b0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q   <= rp_q + 1'b1;
                dout_q <= mem[rp_q];
                ov_q   <= 1'b1;
            end else if (out_ready_i) begin
                ov_q <= 1'b0;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// file: verif/rtdvp_top_sva.sv
// Checker for the value processing top: hand-over, pacing, config apply.
// Assumes it is bound into rtdvp_top and sees its timing parameters.
`timescale 1ns/1ps
module rtdvp_top_sva #(
    parameter CONV_CYC  = 40,
    parameter HAND_CYC  = 10,
    parameter APPLY_CYC = 200
) (
    input wire        clk_i,
    input wire        rstn_i,
    input wire        adc_start_o,
    input wire [1:0]  adc_chan_o,
    input wire        cfg_load_i,
    input wire        cfg_pend_o,
    input wire        bu_valid_o,
    input wire        bu_ready_i,
    input wire [1:0]  bu_chan_o,
    input wire [15:0] bu_data_o
);
    logic [1:0]  next_q;
    logic [31:0] gap_q;
    logic [31:0] pend_q;
    logic [31:0] idle_q;
    logic        seen_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            next_q <= 2'h0;
            gap_q  <= 32'h0000_0000;
            pend_q <= 32'h0000_0000;
            idle_q <= 32'h0000_0000;
            seen_q <= 1'b0;
        end else begin
            if (bu_valid_o && bu_ready_i)
                next_q <= bu_chan_o + 2'h1;
            gap_q  <= adc_start_o ? 32'h0000_0000 : gap_q + 1;
            pend_q <= cfg_pend_o ? pend_q + 1 : 32'h0000_0000;
            idle_q <= bu_valid_o ? 32'h0000_0000 : idle_q + 1;
            if (adc_start_o)
                seen_q <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence taken_s;
        bu_valid_o && bu_ready_i;
    endsequence
    sequence start_s;
        adc_start_o;
    endsequence
    valid_hold_a: assert property (bu_valid_o && !bu_ready_i |=>
        bu_valid_o && $stable(bu_data_o) && $stable(bu_chan_o))
        else $error("word changed before it was taken");
    chan_order_a: assert property (taken_s |-> bu_chan_o == next_q)
        else $error("channel words out of order");
    start_pulse_a: assert property (start_s |=> !adc_start_o)
        else $error("start pulse longer than one cycle");
    conv_gap_a: assert property (start_s ##0 seen_q |->
        gap_q >= CONV_CYC - 1)
        else $error("conversion cut short");
    chan_hold_a: assert property (start_s |=> $stable(adc_chan_o)[*8])
        else $error("channel moved during conversion");
    load_pend_a: assert property (cfg_load_i |=> cfg_pend_o)
        else $error("download not marked pending");
    pend_bound_a: assert property (pend_q <= APPLY_CYC + 2)
        else $error("configuration applied too late");
    hand_rate_a: assert property (idle_q <= HAND_CYC + 6)
        else $error("hand-over interval exceeded");
endmodule
bind rtdvp_top rtdvp_top_sva #(.CONV_CYC(CONV_CYC), .HAND_CYC(HAND_CYC),
    .APPLY_CYC(APPLY_CYC)) u_rtdvp_top_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o),
    .cfg_load_i(cfg_load_i), .cfg_pend_o(cfg_pend_o),
    .bu_valid_o(bu_valid_o), .bu_ready_i(bu_ready_i),
    .bu_chan_o(bu_chan_o), .bu_data_o(bu_data_o));

// file: verif/rtdvp_bu_model.sv
// Bus interface unit model: accepts channel words, stalls at random.
// Assumes the bu_* handshake of the value processing top.
`timescale 1ns/1ps
module rtdvp_bu_model (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        stall_i,
    input  wire        valid_i,
    input  wire [1:0]  chan_i,
    input  wire [15:0] data_i,
    output reg         ready_o,
    output reg  [15:0] word0_o,
    output reg  [7:0]  cnt0_o,
    output reg         err_o
);
    integer   seed;
    reg [1:0] slot_q;
    initial seed = 32'h2ad4;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_o <= 1'b0;
            word0_o <= 16'h0000;
            cnt0_o  <= 8'h00;
            err_o   <= 1'b0;
            slot_q  <= 2'h0;
        end else begin
            // One in four cycles refuses, so the FIFO sees back-pressure
            ready_o <= !stall_i && (($random(seed) & 3) != 0);
            if (valid_i && ready_o) begin
                // Same four-slot layout as the sender expects
                if (chan_i !== slot_q)
                    err_o <= 1'b1;
                slot_q <= slot_q + 2'h1;
                if (chan_i == 2'h0) begin
                    word0_o <= data_i;
                    cnt0_o  <= cnt0_o + 8'h01;
                end
            end
        end
    end
endmodule

// file: verif/rtdvp_top_tb.sv
// Self-checking bench for the value processing top, channel 0 observed.
// Assumes the bus unit model and the checker compiled alongside.
`timescale 1ns/1ps
module rtdvp_top_tb;
    reg         clk = 1'b0, rstn = 1'b0, load = 1'b0, fault = 1'b0;
    reg         stall = 1'b0, sim, wst, sst, slb, sinv, mst, mlb, minv, lfc;
    reg  [15:0] adc = 16'h0000, rs, re, lo, hi, w;
    reg  [8:0]  spct, mpct;
    reg  [7:0]  clr, fpct;
    reg  [1:0]  err;
    reg  [3:0]  act, w3;
    wire        start, pend, valid, ready, perr;
    wire [1:0]  achan, bchan;
    wire [15:0] data, w0;
    wire [7:0]  c0;
    wire [3:0]  cf;
    integer     seed = 32'h2ad4, fails = 0, compares = 0, cyc = 0, i;
    integer     pt [0:4] = '{-25, 0, 50, 100, 125};
    rtdvp_top #(.CONV_CYC(40), .CONV3W_CYC(80), .HAND_CYC(10),
        .APPLY_CYC(200)) u_rtdvp_top (.clk_i(clk), .rstn_i(rstn),
        .adc_start_o(start), .adc_chan_o(achan), .adc_data_i(adc),
        .adc_fault_i(fault), .cfg_load_i(load), .cfg_pend_o(pend),
        .cfg_active_i(act), .cfg_3wire_i(w3), .cfg_sim_i(sim),
        .cfg_err_mode_i(err), .cfg_with_status_i(wst),
        .cfg_range_start_i(rs), .cfg_range_end_i(re), .cfg_min_tx_i(lo),
        .cfg_max_tx_i(hi), .cfg_filter_pct_i(fpct), .cfg_subst_pct_i(spct),
        .cfg_subst_st_i(sst), .cfg_subst_lb_i(slb), .cfg_subst_inv_i(sinv),
        .cfg_sim_pct_i(mpct), .cfg_sim_st_i(mst), .cfg_sim_lb_i(mlb),
        .cfg_sim_inv_i(minv), .cfg_line_fault_check_i(lfc),
        .cfg_fault_clear_cycles_i(clr), .bu_valid_o(valid),
        .bu_ready_i(ready), .bu_chan_o(bchan), .bu_data_o(data),
        .chan_fault_o(cf));
    rtdvp_bu_model u_rtdvp_bu_model (.clk_i(clk), .rstn_i(rstn),
        .stall_i(stall), .valid_i(valid), .chan_i(bchan), .data_i(data),
        .ready_o(ready), .word0_o(w0), .cnt0_o(c0), .err_o(perr));
    always #25 clk = ~clk;
    function [15:0] clampv(input integer v);
        integer l, h;
        begin
            l = lo;
            h = hi;
            clampv = v < l ? lo : (v > h ? hi : v[15:0]);
        end
    endfunction
    function [15:0] pctv(input integer p);
        integer a, b;
        begin
            a = rs;
            b = re;
            pctv = clampv(a + (b - a) * p / 100);
        end
    endfunction
    task check(input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("mismatch at %0t: saw %h expected %h", $time, seen,
                    exp);
            end
        end
    endtask
    task finish_test;
        begin
            if (fails == 0 && compares > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task base;
        begin
            {sim, wst, sst, slb, sinv, mst, mlb, minv, lfc} = 9'h000;
            {act, w3, fpct} = {4'h5, 4'h4, 8'h00};
            {err, clr, spct, mpct} = {2'h0, 8'h03, 9'h000, 9'h000};
            {rs, re, lo, hi} = {16'h2710, 16'hC350, 16'h0000, 16'hFFFF};
        end
    endtask
    task apply;
        begin
            @(negedge clk);
            load = 1'b1;
            @(negedge clk);
            load = 1'b0;
            @(negedge clk);
            while (pend !== 1'b0)
                @(negedge clk);
        end
    endtask
    task starts(input integer n);
        begin
            while (n > 0) begin
                @(negedge clk);
                if (start === 1'b1 && achan === 2'h0)
                    n = n - 1;
            end
        end
    endtask
    // A word counts only once it was converted under the present setup
    task word;
        reg [7:0] goal;
        begin
            starts(3);
            goal = c0 + 8'h02;
            while (c0 !== goal)
                @(negedge clk);
            w = w0;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            finish_test;
        end
    end
    initial begin
        base;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        check({start, pend, valid}, 16'h0000);
        repeat (3) @(negedge clk);
        {sim, lo, hi} = {1'b1, 16'h2000, 16'hE000};
        for (i = 0; i < 5; i = i + 1) begin
            mpct = pt[i];
            apply;
            word;
            check(w, pctv(pt[i]));
        end
        base;
        {err, rs, re, lo, hi} = {2'h1, 16'h0000, 16'hFFFF, 16'h1000, 16'hE000};
        apply;
        for (i = 0; i < 4; i = i + 1) begin
            adc = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : $random(seed);
            word;
            check(w, clampv(adc));
        end
        base;
        {err, lfc, sst, slb, sinv, wst} = {2'h1, 5'h1F};
        {spct, fault} = {9'd100, 1'b1};
        apply;
        word;
        check(w, 16'hC35A);
        check(cf[0], 1'b1);
        re = 16'h9C40;
        apply;
        word;
        check(w, 16'h9C40);
        base;
        {sim, mst, minv, mpct} = {3'h7, 9'd100};
        {err, spct, fault} = {2'h1, 9'd50, 1'b0};
        apply;
        word;
        check(w, 16'h7530);
        base;
        {err, lfc, rs, re, adc} = {3'h5, 16'h0000, 16'hFFFF, 16'h4321};
        apply;
        word;
        {fault, adc} = {1'b1, 16'h1234};
        word;
        check(w, 16'h4321);
        fault = 1'b0;
        starts(2);
        check(cf[0], 1'b1);
        starts(4);
        check(cf[0], 1'b0);
        base;
        {act, fpct, rs, re} = {4'hF, 8'h01, 16'h0000, 16'hFFFF};
        apply;
        adc = 16'hF000;
        word;
        // 1% of full span per second over a 120 ms conversion is 78 counts a step
        check((w - 16'h1234) % 16'd78, 16'h0000);
        check(w >= 16'h12D0 && w <= 16'h1408, 1'b1);
        stall = 1'b1;
        repeat (300) @(negedge clk);
        check(valid, 1'b1);
        stall = 1'b0;
        repeat (400) @(negedge clk);
        check(perr, 1'b0);
        finish_test;
    end
endmodule
